// ### logic/asf_map.vh
`ifndef ASF_MAP_VH
`define ASF_MAP_VH
// register offsets (word index on the plain port)
`define ASF_ADDR_W        4
`define ASF_REG_CFG_LO    4'h0
`define ASF_REG_CFG_HI    4'h1
`define ASF_REG_CTRL      4'h2
`define ASF_REG_STATUS    4'h3
`define ASF_REG_RESULT    4'h4
`define ASF_REG_CFG_COUNT 4'h5
// control register bits
`define ASF_CTRL_CONVERT  0
`define ASF_CTRL_CFG_CLR  1
`define ASF_CTRL_OVF_CLR  2
`define ASF_CTRL_RES_CLR  3
`define ASF_CTRL_WIDE     4
// status register bits
`define ASF_ST_EMPTY      0
`define ASF_ST_HALF       1
`define ASF_ST_FULL       2
`define ASF_ST_OVF        3
`define ASF_ST_BUSY       4
`define ASF_ST_CFG_EMPTY  5
`define ASF_ST_CFG_FULL   6
`define ASF_ST_SCAN_END   7
// config entry layout, 20 bits
`define ASF_CE_W          20
`define ASF_CE_TYPE       2:0
`define ASF_CE_CHAN       6:3
`define ASF_CE_BANK       9:7
`define ASF_CE_GAIN       12:10
`define ASF_CE_UNIPOLAR   13
`define ASF_CE_DITHER     14
`define ASF_CE_TRIG       15
`define ASF_CE_LAST       16
// channel types
`define ASF_TYPE_CAL      3'h0
`define ASF_TYPE_DIFF     3'h1
`define ASF_TYPE_RSE      3'h2
`define ASF_TYPE_NRSE     3'h3
`define ASF_TYPE_GHOST    3'h4
// one-hot mux switch settings, one bit per channel type
`define ASF_MODE_OFF      5'h00
`define ASF_MODE_CAL      5'h01
`define ASF_MODE_DIFF     5'h02
`define ASF_MODE_RSE      5'h04
`define ASF_MODE_NRSE     5'h08
`define ASF_MODE_GHOST    5'h10
// depths
`define ASF_CFG_DEPTH     512
`define ASF_CFG_AW        9
`define ASF_RES_DEPTH     1024
`define ASF_RES_AW        10
`define ASF_RES_HALF      11'h200
`define ASF_CFG_FULL_CNT  10'h200
`define ASF_RES_FULL_CNT  11'h400
`endif

// ### logic/asf_scan_fifo.v
`timescale 1ns/100ps
`default_nettype none
`include "asf_map.vh"

// Notes on behaviour
// - config store is a 512-entry fifo; host loads at least one entry before acquiring
// - entry holds type, channel, bank, gain, polarity, dither, trigger, last mark
// - config advances one entry at every conversion start
// - on running empty a retransmit rewinds config to its loaded contents
// - channel type drives mux mode switches: cal, diff, rse, nrse, ghost
// - ghost entries convert but their result is discarded
// - channel number selects within type; bank selects group of 16
// - gain code drives amp: eight gains narrow, four gains wide
// - polarity selects unipolar or bipolar operation
// - dither per entry; forced on for the 16-bit variant
// - last-channel mark ends the scan on that conversion
// - result resolution is 12 or 16 bits
// - wide results: two's complement bipolar, straight unipolar
// - result store is a 16-bit, 1k-word fifo
// - each finished non-ghost conversion pushes its result into the fifo
// - push while full raises overflow and drops the result
// - empty, half-full and full flags are provided
// - conversion starts on convert pin low, interval edge, or software strobe
// - push strobe clears the empty flag
module asf_scan_fifo (
  input  wire        clk,
  input  wire        reset,
  input  wire [3:0]  addr,
  input  wire [31:0] wdata,
  input  wire        wr_stb,
  input  wire        rd_stb,
  output reg  [31:0] rdata,
  input  wire        convert_n,
  input  wire        sample_interval,
  output reg         conv_start,
  input  wire        conv_done,
  input  wire [15:0] conv_data,
  output reg  [4:0]  mux_mode,
  output reg  [3:0]  mux_chan,
  output reg  [2:0]  mux_bank,
  output reg  [2:0]  programmable_gain_amp,
  output reg         amp_unipolar,
  output reg         dither_en,
  output reg         general_trig,
  output reg         scan_end,
  output reg         result_push_strobe_n,
  output wire        result_fifo_empty_flag,
  output wire        result_fifo_half,
  output wire        result_fifo_full,
  output wire        result_fifo_overflow
);

  // address decode helper, used on both strobes
  function hit;
    input [3:0] a;
    input [3:0] r;
    begin
      hit = (a == r);
    end
  endfunction

  // wide variant keeps four gains: codes map onto 1,2,10,100
  function [2:0] gain_map;
    input       wide;
    input [2:0] code;
    begin
      if (wide) begin
        gain_map = {1'b0, code[1:0]};
      end else begin
        gain_map = code;
      end
    end
  endfunction

  // channel type to one-hot switch setting; unknown codes open every switch
  function [4:0] mode_onehot;
    input [2:0] kind;
    begin
      case (kind)
        `ASF_TYPE_CAL:   mode_onehot = `ASF_MODE_CAL;
        `ASF_TYPE_DIFF:  mode_onehot = `ASF_MODE_DIFF;
        `ASF_TYPE_RSE:   mode_onehot = `ASF_MODE_RSE;
        `ASF_TYPE_NRSE:  mode_onehot = `ASF_MODE_NRSE;
        `ASF_TYPE_GHOST: mode_onehot = `ASF_MODE_GHOST;
        default:         mode_onehot = `ASF_MODE_OFF;
      endcase
    end
  endfunction

  // narrow variant keeps the low 12 bits; wide passes all 16 untouched
  function [15:0] result_fit;
    input        wide;
    input [15:0] raw;
    begin
      if (wide) begin
        result_fit = raw;
      end else begin
        result_fit = {4'h0, raw[11:0]};
      end
    end
  endfunction

  // config storage
  reg [`ASF_CE_W-1:0]   cfg_mem [0:`ASF_CFG_DEPTH-1];
  reg [`ASF_CFG_AW-1:0] cfg_wp_q;
  reg [`ASF_CFG_AW-1:0] cfg_rp_q;
  reg [`ASF_CFG_AW:0]   cfg_cnt_q;
  reg [`ASF_CFG_AW:0]   cfg_left_q;
  reg [15:0]            cfg_lo_q;
  reg                   wide_q;
  // result storage
  reg [15:0]            res_mem [0:`ASF_RES_DEPTH-1];
  reg [`ASF_RES_AW-1:0] res_wp_q;
  reg [`ASF_RES_AW-1:0] res_rp_q;
  reg [`ASF_RES_AW:0]   res_cnt_q;
  reg                   ovf_q;
  reg                   busy_q;
  reg                   scan_end_q;
  reg                   conv_n_q;
  reg                   interval_q;
  reg [`ASF_CE_W-1:0]   cur_q;
  reg [`ASF_RES_AW:0]   res_cnt_d;
  reg [7:0]             status_w;
  reg [31:0]            ctrl_w;

  wire cfg_wr   = wr_stb && hit(addr, `ASF_REG_CFG_HI);
  wire ctrl_wr  = wr_stb && hit(addr, `ASF_REG_CTRL);
  wire res_rd   = rd_stb && hit(addr, `ASF_REG_RESULT);
  wire cfg_full = (cfg_cnt_q == `ASF_CFG_FULL_CNT);
  wire cfg_empty = (cfg_cnt_q == {(`ASF_CFG_AW+1){1'b0}});
  wire res_empty = (res_cnt_q == {(`ASF_RES_AW+1){1'b0}});

  // three start sources: pin low pulse, interval falling edge, strobe
  wire pin_fall = conv_n_q && !convert_n;
  wire int_fall = interval_q && !sample_interval;
  wire sw_conv  = ctrl_wr && wdata[`ASF_CTRL_CONVERT];
  wire start    = (pin_fall || int_fall || sw_conv) && !busy_q && !cfg_empty;

  wire cur_ghost = (cur_q[`ASF_CE_TYPE] == `ASF_TYPE_GHOST);
  wire done_ok  = busy_q && conv_done;
  wire push     = done_ok && !cur_ghost && !result_fifo_full;
  wire drop     = done_ok && !cur_ghost && result_fifo_full;
  wire pop      = res_rd && !res_empty;
  wire res_clr  = ctrl_wr && wdata[`ASF_CTRL_RES_CLR];
  wire cfg_clr  = ctrl_wr && wdata[`ASF_CTRL_CFG_CLR];
  wire ovf_clr  = ctrl_wr && wdata[`ASF_CTRL_OVF_CLR];
  wire last_done = done_ok && cur_q[`ASF_CE_LAST];
  wire cfg_lo_wr = wr_stb && hit(addr, `ASF_REG_CFG_LO);

  // config bookkeeping: a load and a start may share a cycle
  wire [`ASF_CFG_AW:0] cfg_one  = {{`ASF_CFG_AW{1'b0}}, 1'b1};
  wire                 cfg_load = cfg_wr && !cfg_full;
  wire [`ASF_CFG_AW:0] cfg_inc  = {{`ASF_CFG_AW{1'b0}}, cfg_load};
  wire                 cfg_retx = start && (cfg_left_q == cfg_one);

  // config fifo write side; load only, no entry is ever consumed away
  always @(posedge clk) begin
    if (cfg_load) begin
      cfg_mem[cfg_wp_q] <= {wdata[`ASF_CE_W-17:0], cfg_lo_q};
    end
  end

  // software side registers: staged low half of an entry and the variant bit
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      cfg_lo_q <= 16'h0000;
      wide_q   <= 1'b0;
    end else begin
      if (cfg_lo_wr) begin
        cfg_lo_q <= wdata[15:0];
      end
      if (ctrl_wr) begin
        wide_q <= wdata[`ASF_CTRL_WIDE];
      end
    end
  end

  // config load side; a clear empties the store and forgets the whole load
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      cfg_wp_q  <= {`ASF_CFG_AW{1'b0}};
      cfg_cnt_q <= {(`ASF_CFG_AW+1){1'b0}};
    end else if (cfg_clr) begin
      cfg_wp_q  <= {`ASF_CFG_AW{1'b0}};
      cfg_cnt_q <= {(`ASF_CFG_AW+1){1'b0}};
    end else if (cfg_load) begin
      cfg_wp_q  <= cfg_wp_q + 1'b1;
      cfg_cnt_q <= cfg_cnt_q + 1'b1;
    end
  end

  // config read side, kept apart from loading so a start that lands on a
  // load cycle still advances; retransmit rewinds to the first entry
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      cfg_rp_q   <= {`ASF_CFG_AW{1'b0}};
      cfg_left_q <= {(`ASF_CFG_AW+1){1'b0}};
    end else if (cfg_clr) begin
      cfg_rp_q   <= {`ASF_CFG_AW{1'b0}};
      cfg_left_q <= {(`ASF_CFG_AW+1){1'b0}};
    end else if (cfg_retx) begin
      cfg_rp_q   <= {`ASF_CFG_AW{1'b0}};
      cfg_left_q <= cfg_cnt_q + cfg_inc;
    end else if (start) begin
      cfg_rp_q   <= cfg_rp_q + 1'b1;
      cfg_left_q <= cfg_left_q - 1'b1 + cfg_inc;
    end else begin
      cfg_left_q <= cfg_left_q + cfg_inc;
    end
  end

  // previous pin levels for edge detection; the convert pin idles high, so
  // its history starts high and reset release cannot fake an edge
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      conv_n_q   <= 1'b1;
      interval_q <= 1'b0;
    end else begin
      conv_n_q   <= convert_n;
      interval_q <= sample_interval;
    end
  end

  // conversion sequencing; entry latched at start holds the front end steady
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      busy_q     <= 1'b0;
      cur_q      <= {`ASF_CE_W{1'b0}};
      conv_start <= 1'b0;
    end else begin
      conv_start <= start;
      if (start) begin
        busy_q <= 1'b1;
        cur_q  <= cfg_mem[cfg_rp_q];
      end else if (done_ok) begin
        busy_q <= 1'b0;
      end
    end
  end

  // scan end: a pulse for the timing side and a sticky copy for software
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      scan_end_q <= 1'b0;
      scan_end   <= 1'b0;
    end else begin
      scan_end <= last_done;
      if (last_done) begin
        scan_end_q <= 1'b1;
      end else if (start) begin
        scan_end_q <= 1'b0;
      end
    end
  end

  // front end drive from the latched entry
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      mux_mode              <= 5'h00;
      mux_chan              <= 4'h0;
      mux_bank              <= 3'h0;
      programmable_gain_amp <= 3'h0;
      amp_unipolar          <= 1'b0;
      dither_en             <= 1'b0;
      general_trig          <= 1'b0;
    end else begin
      mux_mode              <= mode_onehot(cur_q[`ASF_CE_TYPE]);
      mux_chan              <= cur_q[`ASF_CE_CHAN];
      mux_bank              <= cur_q[`ASF_CE_BANK];
      programmable_gain_amp <= gain_map(wide_q, cur_q[`ASF_CE_GAIN]);
      amp_unipolar          <= cur_q[`ASF_CE_UNIPOLAR];
      dither_en             <= cur_q[`ASF_CE_DITHER] || wide_q;
      general_trig          <= cur_q[`ASF_CE_TRIG];
    end
  end

  // result write; narrow results keep the low 12 bits, coding passes through
  always @(posedge clk) begin
    if (push) begin
      res_mem[res_wp_q] <= result_fit(wide_q, conv_data);
    end
  end

  // result occupancy next value; a push and a pop together leave it alone
  always @* begin
    res_cnt_d = res_cnt_q;
    if (push && !pop) begin
      res_cnt_d = res_cnt_q + 1'b1;
    end else if (pop && !push) begin
      res_cnt_d = res_cnt_q - 1'b1;
    end
  end

  // result pointers; a clear wins over a push or pop in the same cycle
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      res_wp_q  <= {`ASF_RES_AW{1'b0}};
      res_rp_q  <= {`ASF_RES_AW{1'b0}};
      res_cnt_q <= {(`ASF_RES_AW+1){1'b0}};
    end else if (res_clr) begin
      res_wp_q  <= {`ASF_RES_AW{1'b0}};
      res_rp_q  <= {`ASF_RES_AW{1'b0}};
      res_cnt_q <= {(`ASF_RES_AW+1){1'b0}};
    end else begin
      if (push) begin
        res_wp_q <= res_wp_q + 1'b1;
      end
      if (pop) begin
        res_rp_q <= res_rp_q + 1'b1;
      end
      res_cnt_q <= res_cnt_d;
    end
  end

  // sticky overflow; the set beats a clear that lands in the same cycle
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      ovf_q <= 1'b0;
    end else if (drop) begin
      ovf_q <= 1'b1;
    end else if (ovf_clr) begin
      ovf_q <= 1'b0;
    end
  end

  // push strobe, low for one cycle after each kept result
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      result_push_strobe_n <= 1'b1;
    end else begin
      result_push_strobe_n <= !push;
    end
  end

  assign result_fifo_empty_flag = res_empty;
  assign result_fifo_half       = (res_cnt_q >= `ASF_RES_HALF);
  assign result_fifo_full       = (res_cnt_q == `ASF_RES_FULL_CNT);
  assign result_fifo_overflow   = ovf_q;

  // status word built bit by bit so each flag sits at its mapped place
  always @* begin
    status_w                    = 8'h00;
    status_w[`ASF_ST_EMPTY]     = res_empty;
    status_w[`ASF_ST_HALF]      = result_fifo_half;
    status_w[`ASF_ST_FULL]      = result_fifo_full;
    status_w[`ASF_ST_OVF]       = ovf_q;
    status_w[`ASF_ST_BUSY]      = busy_q;
    status_w[`ASF_ST_CFG_EMPTY] = cfg_empty;
    status_w[`ASF_ST_CFG_FULL]  = cfg_full;
    status_w[`ASF_ST_SCAN_END]  = scan_end_q;
  end

  // control readback: only the variant bit holds state, strobes read zero
  always @* begin
    ctrl_w                 = 32'h00000000;
    ctrl_w[`ASF_CTRL_WIDE] = wide_q;
  end

  // read data, one cycle after the strobe; unmapped reads give zero
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata <= 32'h00000000;
    end else if (rd_stb) begin
      case (addr)
        `ASF_REG_CFG_LO:    rdata <= {16'h0000, cfg_lo_q};
        `ASF_REG_CTRL:      rdata <= ctrl_w;
        `ASF_REG_STATUS:    rdata <= {24'h000000, status_w};
        `ASF_REG_RESULT:    rdata <= res_empty ? 32'h00000000
                                               : {16'h0000, res_mem[res_rp_q]};
        `ASF_REG_CFG_COUNT: rdata <= {22'h000000, cfg_cnt_q};
        default:            rdata <= 32'h00000000;
      endcase
    end else begin
      rdata <= 32'h00000000;
    end
  end

endmodule
`default_nettype wire

// ### tb/asf_front_model.sv
`timescale 1ns/100ps
`default_nettype none
module asf_front_model (
  input  wire logic        clk,
  input  wire logic        conv_start,
  input  wire logic        slow,
  input  wire logic [15:0] sample,
  output var  logic        conv_done,
  output var  logic [15:0] conv_data
);
  int wait_q = 0;
  initial conv_done = 1'b0;
  initial conv_data = 16'h0000;
  // converter: short or long conversion, data bus toggles on every cycle except the done cycle
  always @(posedge clk) begin
    conv_done <= 1'b0;
    conv_data <= ~conv_data;
    if (conv_start) begin
      wait_q <= slow ? 12 : 3;
    end else if (wait_q > 0) begin
      wait_q <= wait_q - 1;
      if (wait_q == 1) begin
        conv_done <= 1'b1;
        conv_data <= sample;
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/asf_scan_fifo_props.sv
`timescale 1ns/100ps
`default_nettype none
module asf_scan_props (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       conv_start,
  input wire logic       conv_done,
  input wire logic [4:0] mux_mode,
  input wire logic       scan_end,
  input wire logic       result_push_strobe_n,
  input wire logic       result_fifo_empty_flag,
  input wire logic       result_fifo_half,
  input wire logic       result_fifo_full,
  input wire logic       result_fifo_overflow
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // a result that must be kept, then a one-cycle low strobe
  sequence s_keep;
    conv_done && !mux_mode[4] && !result_fifo_full;
  endsequence
  sequence s_strobe;
    !result_push_strobe_n ##1 result_push_strobe_n;
  endsequence
  chk_push_after_done: assert property (s_keep |=> s_strobe)
    else $error("no push strobe after kept result");
  chk_ghost_no_push: assert property (conv_done && mux_mode[4] |=> result_push_strobe_n)
    else $error("ghost result was pushed");
  chk_push_not_empty: assert property (!result_push_strobe_n |-> !result_fifo_empty_flag)
    else $error("empty flag set after push");
  chk_full_ovf: assert property (conv_done && !mux_mode[4] && result_fifo_full
    |=> $rose(result_fifo_overflow) || result_fifo_overflow)
    else $error("no overflow on push into full store");
  chk_full_flags: assert property (result_fifo_full |-> result_fifo_half && !result_fifo_empty_flag)
    else $error("full flag disagrees with others");
  chk_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start longer than one cycle");
  chk_end_pulse: assert property (scan_end |=> !scan_end)
    else $error("scan end longer than one cycle");
  chk_mode_onehot: assert property ($onehot0(mux_mode))
    else $error("mux mode not one-hot");
endmodule
bind asf_scan_fifo asf_scan_props props_inst (
  .clk(clk),
  .reset(reset),
  .conv_start(conv_start),
  .conv_done(conv_done),
  .mux_mode(mux_mode),
  .scan_end(scan_end),
  .result_push_strobe_n(result_push_strobe_n),
  .result_fifo_empty_flag(result_fifo_empty_flag),
  .result_fifo_half(result_fifo_half),
  .result_fifo_full(result_fifo_full),
  .result_fifo_overflow(result_fifo_overflow)
);
`default_nettype wire

// ### tb/adc_scan_config_and_sample_fifo_test.sv
`timescale 1ns/100ps
`default_nettype none
module adc_scan_config_and_sample_fifo_test;
  logic clk, reset, wr_stb, rd_stb, convert_n, sample_interval, slow, wide;
  logic conv_start, conv_done, uni, dith, trig;
  logic scan_end_o, push_n, empty_o, half_o, full_o, ovf_o;
  logic [3:0]  addr, mux_chan;
  logic [31:0] wdata, rdata, st;
  logic [15:0] sample, conv_data;
  logic [4:0]  mux_mode;
  logic [2:0]  mux_bank, gain;
  int          failures, tests_run, i, n;
  // rows: entry {last,trig,dith,uni,gain,bank,chan,type} beside raw sample
  logic [16:0] ent [5] = '{17'h05499, 17'h0a83a, 17'h0000c, 17'h11ffb, 17'h10400};
  logic [15:0] smp [5] = '{16'habcd, 16'h1234, 16'h5555, 16'hf00f, 16'h0fff};
  asf_scan_fifo asf_scan_fifo_inst (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .convert_n(convert_n),
    .sample_interval(sample_interval), .conv_start(conv_start), .conv_done(conv_done),
    .conv_data(conv_data), .mux_mode(mux_mode), .mux_chan(mux_chan), .mux_bank(mux_bank),
    .programmable_gain_amp(gain), .amp_unipolar(uni), .dither_en(dith), .general_trig(trig),
    .scan_end(scan_end_o), .result_push_strobe_n(push_n), .result_fifo_empty_flag(empty_o),
    .result_fifo_half(half_o), .result_fifo_full(full_o), .result_fifo_overflow(ovf_o));
  asf_front_model asf_front_model_inst (.clk(clk), .conv_start(conv_start), .slow(slow),
    .sample(sample), .conv_done(conv_done), .conv_data(conv_data));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task chk(input [31:0] g, input [31:0] e);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task wr(input [3:0] a, input [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  task rd(input [3:0] a, output [31:0] d);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  function [31:0] exp_mux(input [16:0] e);
    exp_mux = {14'h0, 5'h01 << e[2:0], e[6:3], e[9:7], e[12:10], e[13], e[14], e[15]};
  endfunction
  // start by strobe, pin or interval edge; check mux levels mid-conversion
  task conv(input int how, input [15:0] s, input [31:0] em);
    sample <= s;
    slow <= s[0];
    if (how == 0) wr(4'h2, {27'h0, wide, 4'h1});
    else begin
      @(posedge clk);
      if (how == 1) convert_n <= 1'b0;
      else sample_interval <= 1'b0;
      @(posedge clk);
      convert_n <= 1'b1;
      sample_interval <= 1'b1;
    end
    for (n = 0; n < 20 && conv_start !== 1'b1; n++) @(negedge clk);
    @(negedge clk);
    chk({14'h0, mux_mode, mux_chan, mux_bank, gain, uni, dith, trig}, em);
    for (n = n; n < 40 && conv_done !== 1'b1; n++) @(negedge clk);
    if (n >= 40) failures++;
    repeat (2) @(posedge clk);
  endtask
  task end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    end_of_test;
  end
  initial begin
    {reset, convert_n, sample_interval} = 3'b111;
    {addr, wdata, wr_stb, rd_stb, slow, wide, sample} = '0;
    {failures, tests_run} = '0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    rd(4'h3, st);
    chk(st, 32'h21);
    for (i = 0; i < 5; i++) begin
      wr(4'h0, {15'h0, ent[i]});
      wr(4'h1, {31'h0, ent[i][16]});
    end
    // fifth start rewinds, so the sixth converts the first entry
    for (i = 0; i < 6; i++) begin
      conv(i % 3, smp[i % 5], exp_mux(ent[i % 5]));
      chk({31'h0, empty_o}, {31'h0, ent[i % 5][2:0] == 3'h4});
      rd(4'h4, st);
      chk({31'h0, empty_o}, 32'h1);
      chk(st, ent[i % 5][2:0] == 3'h4 ? 32'h0 : {20'h0, smp[i % 5][11:0]});
      rd(4'h3, st);
      chk({31'h0, st[7]}, {31'h0, ent[i % 5][16]});
    end
    $display("table test done");
    // wide mode: fill past 1k words, gain trimmed and dither forced
    wide <= 1'b1;
    wr(4'h2, 32'h1a);
    wr(4'h0, 32'h1c01);
    wr(4'h1, 32'h0);
    for (i = 0; i < 1025; i++) conv(i % 3, 16'h8000 ^ i[15:0], 32'h401a);
    rd(4'h3, st);
    chk(st & 32'hf, 32'he);
    chk({28'h0, empty_o, half_o, full_o, ovf_o}, 32'h7);
    rd(4'h4, st);
    chk(st, 32'h8000);
    rd(4'h4, st);
    chk(st, 32'h8001);
    wr(4'h2, 32'h14);
    rd(4'h3, st);
    chk(st & 32'hf, 32'h2);
    $display("overflow test done");
    // reset in mid-run with words still stored: everything back to idle
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd(4'h3, st);
    chk(st, 32'h21);
    chk({27'h0, empty_o, half_o, full_o, ovf_o, push_n}, 32'h11);
    $display("reset test done");
    end_of_test;
  end
endmodule
`default_nettype wire
